// file: hdl/dbsp_pkg.sv
// Shared constants of the two-beat DDR static memory port
package dbsp_pkg;
   // =========================================================
   // Organization
   localparam int DW_X36 = 36;
   localparam int DW_X18 = 18;
   localparam int AW_X36 = 19;
   localparam int AW_X18 = 20;
   localparam int NL_X36 = 4;
   localparam int NL_X18 = 2;
   localparam int LANE_W = 9;
   localparam int BURST_LEN = 2;
   // =========================================================
   // Pipeline and buffering
   localparam int SYNC_STAGES = 2;
   localparam int WBUF_DEPTH = 8;
   localparam int CTRL_PINS = 5;
   // Index of each control bit in the synchronised bundle
   localparam int PIN_K = 4;
   localparam int PIN_KN = 3;
   localparam int PIN_RN = 2;
   localparam int PIN_WN = 1;
   localparam int PIN_DOFFN = 0;
   // =========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int LINK_PERIOD_NS = 200;
   localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage : dbsp_pkg

// file: hdl/dbsp_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dbsp_sync
   import dbsp_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] safe;
   } dbsp_sync_t;

   dbsp_sync_t s_reg;
   dbsp_sync_t s_next;

   // First stage is read only by the second
   always_comb begin
      s_next = s_reg;
      if (ce) begin
         s_next.meta = d;
         s_next.safe = s_reg.meta;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.safe;
endmodule : dbsp_sync
`default_nettype wire

// file: hdl/dbsp_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dbsp_fifo
   import dbsp_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = WBUF_DEPTH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } dbsp_fifo_t;

   dbsp_fifo_t f_reg;
   dbsp_fifo_t f_next;
   logic push;
   logic pop;

   assign in_ready = (f_reg.cnt != FULL);
   assign out_valid = (f_reg.cnt != '0);
   assign out_data = f_reg.mem[f_reg.rp];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.mem[f_reg.wp] = in_data;
         f_next.wp = (f_reg.wp == LAST) ? '0 : f_reg.wp + 1'b1;
      end
      if (pop) begin
         f_next.rp = (f_reg.rp == LAST) ? '0 : f_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         f_next.cnt = f_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         f_next.cnt = f_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end
endmodule : dbsp_fifo
`default_nettype wire

// file: hdl/dbsp_sram_port.sv
// Device-side logic of the two-beat DDR static memory port
`timescale 1ns/1ps
`default_nettype none
module dbsp_sram_port
   import dbsp_pkg::*;
#(
   parameter bit WIDE_ORG = 1'b1,
   parameter int STORE_AW = 10,
   localparam int DW = WIDE_ORG ? DW_X36 : DW_X18,
   localparam int AW = WIDE_ORG ? AW_X36 : AW_X18,
   localparam int NL = WIDE_ORG ? NL_X36 : NL_X18
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic input_clock_true,
   input wire logic input_clock_comp,
   input wire logic read_sel_n,
   input wire logic write_sel_n,
   input wire logic [AW-1:0] shared_address_in,
   input wire logic [NL-1:0] byte_lane_write_n,
   input wire logic [DW-1:0] write_data_in,
   input wire logic dll_off_n,
   output logic [DW-1:0] read_data_out,
   output logic read_data_oe_n,
   output logic read_valid_flag,
   output logic echo_clock_true,
   output logic echo_clock_comp
);
   // =========================================================
   // Local widths
   localparam int SW = CTRL_PINS + AW + NL + DW;
   localparam int EW = AW + BURST_LEN * (DW + NL);
   localparam int BW2 = BURST_LEN * DW;

   // Write entry layout: address, beat0, beat1, lanes0, lanes1
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] d0;
      logic [DW-1:0] d1;
      logic [NL-1:0] bn0;
      logic [NL-1:0] bn1;
   } dbsp_wentry_t;

   typedef struct packed {
      logic k_prev;
      logic kn_prev;
      logic wr_cmd;
      logic [DW-1:0] wd0;
      logic [NL-1:0] wb0;
      logic [1:0] rd_sh;
      logic [AW-1:0] ra0;
      logic [AW-1:0] ra1;
      logic push_valid;
      dbsp_wentry_t push_word;
      logic [DW-1:0] beat1;
      logic b1_due;
      logic [DW-1:0] q;
      logic vld;
      logic ech_t;
      logic ech_c;
   } dbsp_state_t;

   dbsp_state_t s_reg;
   dbsp_state_t s_next;

   // =========================================================
   // Pin synchronisation
   logic [SW-1:0] pins_raw;
   logic [SW-1:0] pins_s;
   logic k_s;
   logic kn_s;
   logic rn_s;
   logic wn_s;
   logic doffn_s;
   logic [AW-1:0] addr_s;
   logic [NL-1:0] bwn_s;
   logic [DW-1:0] d_s;

   // Clock pins travel with the data pins so edges and values line up
   assign pins_raw = {input_clock_true, input_clock_comp, read_sel_n, write_sel_n,
                      dll_off_n, shared_address_in, byte_lane_write_n, write_data_in};

   dbsp_sync #(
      .W(SW)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .d(pins_raw),
      .q(pins_s)
   );

   assign k_s = pins_s[SW-1-(CTRL_PINS-1-PIN_K)];
   assign kn_s = pins_s[SW-1-(CTRL_PINS-1-PIN_KN)];
   assign rn_s = pins_s[SW-1-(CTRL_PINS-1-PIN_RN)];
   assign wn_s = pins_s[SW-1-(CTRL_PINS-1-PIN_WN)];
   assign doffn_s = pins_s[SW-1-(CTRL_PINS-1-PIN_DOFFN)];
   assign addr_s = pins_s[NL+DW +: AW];
   assign bwn_s = pins_s[DW +: NL];
   assign d_s = pins_s[0 +: DW];

   // =========================================================
   // Edge detection and decode
   logic k_rise;
   logic kn_rise;
   logic lat1;
   logic rd_due;
   logic [AW-1:0] rd_addr;
   logic fetch;

   assign k_rise = ce && k_s && !s_reg.k_prev;
   assign kn_rise = ce && kn_s && !s_reg.kn_prev;
   assign lat1 = !doffn_s;
   assign rd_due = lat1 ? s_reg.rd_sh[0] : s_reg.rd_sh[1];
   assign rd_addr = lat1 ? s_reg.ra0 : s_reg.ra1;
   assign fetch = kn_rise && rd_due;

   // =========================================================
   // Write buffer and array
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [EW-1:0] fifo_out_data;
   dbsp_wentry_t head;
   logic [BW2-1:0] store [2**STORE_AW];

   assign head = dbsp_wentry_t'(fifo_out_data);
   // Drain stalls only while a read fetches the array
   assign fifo_out_ready = !fetch;

   dbsp_fifo #(
      .W(EW),
      .DEPTH(WBUF_DEPTH)
   ) u_wbuf (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .in_valid(s_reg.push_valid),
      .in_ready(fifo_in_ready),
      .in_data(s_reg.push_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Merge only enabled lanes of each beat
   function automatic logic [BW2-1:0] lane_merge(input logic [BW2-1:0] base,
                                                  input dbsp_wentry_t w);
      logic [BW2-1:0] r;
      r = base;
      for (int ln = 0; ln < NL; ln++) begin
         if (!w.bn0[ln]) begin
            r[DW + ln*LANE_W +: LANE_W] = w.d0[ln*LANE_W +: LANE_W];
         end
         if (!w.bn1[ln]) begin
            r[ln*LANE_W +: LANE_W] = w.d1[ln*LANE_W +: LANE_W];
         end
      end
      return r;
   endfunction : lane_merge

   // Array is left out of reset: it is storage, not control state
   always_ff @(posedge clk) begin
      if (ce && fifo_out_valid && fifo_out_ready) begin
         store[head.addr[STORE_AW-1:0]] <= lane_merge(store[head.addr[STORE_AW-1:0]], head);
      end
   end

   // Forward the buffer head entry and the staged write, staged entry newest
   logic [BW2-1:0] rd_word;
   always_comb begin
      rd_word = store[rd_addr[STORE_AW-1:0]];
      if (fifo_out_valid && head.addr == rd_addr) begin
         rd_word = lane_merge(rd_word, head);
      end
      if (s_reg.push_valid && s_reg.push_word.addr == rd_addr) begin
         rd_word = lane_merge(rd_word, s_reg.push_word);
      end
   end

   // =========================================================
   // Next state
   always_comb begin
      s_next = s_reg;
      if (ce) begin
         s_next.k_prev = k_s;
         s_next.kn_prev = kn_s;
         // Echo pair follows the input clocks while ce is high
         s_next.ech_t = k_s;
         s_next.ech_c = kn_s;
         if (s_reg.push_valid && fifo_in_ready) begin
            s_next.push_valid = 1'b0;
         end
      end
      // Read side captured on the true clock
      if (k_rise) begin
         s_next.rd_sh = {s_reg.rd_sh[0], !rn_s};
         s_next.ra1 = s_reg.ra0;
         if (!rn_s) begin
            s_next.ra0 = addr_s;
         end
         // First write beat with the command
         s_next.wr_cmd = !wn_s;
         if (!wn_s) begin
            s_next.wd0 = d_s;
            s_next.wb0 = bwn_s;
         end
         // Second read beat on the true edge
         if (s_reg.b1_due) begin
            s_next.q = s_reg.beat1;
            s_next.b1_due = 1'b0;
         end
      end
      // Write address and lanes on the complement edge
      if (kn_rise) begin
         // Write address shares pins half a cycle later
         if (s_reg.wr_cmd) begin
            s_next.wr_cmd = 1'b0;
            s_next.push_valid = 1'b1;
            s_next.push_word.addr = addr_s;
            s_next.push_word.d0 = s_reg.wd0;
            s_next.push_word.d1 = d_s;
            s_next.push_word.bn0 = s_reg.wb0;
            s_next.push_word.bn1 = bwn_s;
         end
         // First read beat on the complement edge
         if (rd_due) begin
            s_next.q = rd_word[DW +: DW];
            s_next.beat1 = rd_word[0 +: DW];
            s_next.b1_due = 1'b1;
            s_next.vld = 1'b1;
         end else begin
            s_next.vld = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =========================================================
   // Outputs
   // Echo clocks change on the same edge as data
   assign echo_clock_true = s_reg.ech_t;
   assign echo_clock_comp = s_reg.ech_c;
   assign read_data_out = s_reg.q;
   // Valid spans both beats of a burst
   assign read_valid_flag = s_reg.vld;
   assign read_data_oe_n = !s_reg.vld;

   // =========================================================
   // Checks
   // Organization widths
   AST_ORG_WIDTH: assert property (@(posedge clk) disable iff (!arst_n)
      NL * LANE_W == DW && (WIDE_ORG ? AW == AW_X36 : AW == AW_X18))
      else $error("width does not match organization");

   AST_LANES: assert property (@(posedge clk) disable iff (!arst_n)
      NL == (WIDE_ORG ? NL_X36 : NL_X18))
      else $error("wrong number of byte lanes");

   AST_PUSH: assert property (@(posedge clk) disable iff (!arst_n)
      (kn_rise && s_reg.wr_cmd) |=> (s_reg.push_valid
         && s_reg.push_word.d1 == $past(d_s) && s_reg.push_word.addr == $past(addr_s)))
      else $error("write beat not staged on complement edge");

   // Staged entry never meets a full buffer
   AST_STAGE_ACCEPT: assert property (@(posedge clk) disable iff (!arst_n)
      s_reg.push_valid |-> fifo_in_ready)
      else $error("staged write met a full buffer");

   AST_WR_CAPTURE: assert property (@(posedge clk) disable iff (!arst_n)
      (k_rise && !wn_s) |=> (s_reg.wr_cmd && s_reg.wd0 == $past(d_s)
         && s_reg.wb0 == $past(bwn_s)))
      else $error("first write beat not taken with command");

   AST_RD_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
      (k_rise && !rn_s) |=> (s_reg.ra0 == $past(addr_s) && s_reg.rd_sh[0]))
      else $error("read address not taken on true edge");

   AST_BEAT0: assert property (@(posedge clk) disable iff (!arst_n)
      fetch |=> (s_reg.vld && s_reg.q == $past(rd_word[DW +: DW])))
      else $error("first read beat wrong");

   AST_BEAT1: assert property (@(posedge clk) disable iff (!arst_n)
      (k_rise && s_reg.b1_due) |=> (s_reg.q == $past(s_reg.beat1) && s_reg.vld))
      else $error("second read beat wrong");

   AST_LAT2: assert property (@(posedge clk) disable iff (!arst_n)
      (k_rise && !rn_s && doffn_s && s_reg.rd_sh == 2'b00 && ce)
         |-> ##[10:14] (read_valid_flag && !read_data_oe_n))
      else $error("read not returned after two cycles");

   AST_LAT1: assert property (@(posedge clk) disable iff (!arst_n)
      (k_rise && !rn_s && !doffn_s && ce) |-> ##[2:6] read_valid_flag)
      else $error("bypass read not returned after one cycle");

   AST_VALID_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
      $changed(read_valid_flag) |-> $rose(echo_clock_comp))
      else $error("valid edge not aligned with echo edge");

   AST_ECHO_RUN: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && $rose(k_s)) |=> (echo_clock_true && !$past(echo_clock_true)))
      else $error("echo clock did not follow input clock");

   AST_ECHO_COMP: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && $rose(kn_s)) |=> (echo_clock_comp && !$past(echo_clock_comp)))
      else $error("complement echo did not follow input clock");

   AST_IGNORE: assert property (@(posedge clk) disable iff (!arst_n)
      (k_rise && rn_s && wn_s) |=> ($stable(s_reg.ra0) && !s_reg.wr_cmd))
      else $error("address taken while deselected");

   AST_NO_DATA: assert property (@(posedge clk) disable iff (!arst_n)
      (kn_rise && !rd_due) |=> (!read_valid_flag && read_data_oe_n))
      else $error("valid without read data");

   AST_DRAIN: assert property (@(posedge clk) disable iff (!arst_n)
      (kn_rise && rd_due && s_reg.wr_cmd) |=> (read_valid_flag && s_reg.push_valid))
      else $error("read and write did not both progress");
endmodule : dbsp_sram_port
`default_nettype wire

// file: verification/dbsp_host_model.sv
// Host controller model: free link clock pair, commands and write beats
`timescale 1ns/1ps
`default_nettype none
module dbsp_host_model
   import dbsp_pkg::*;
#(
   parameter int AW = AW_X36,
   parameter int DW = DW_X36,
   parameter int NL = NL_X36
) (
   output logic link_k,
   output logic link_kn,
   output logic read_sel_n,
   output logic write_sel_n,
   output logic [AW-1:0] addr,
   output logic [NL-1:0] lanes_n,
   output logic [DW-1:0] wdata
);
   localparam int HALF = LINK_PERIOD_NS / 2;
   // ==========
   // Link clocks, phase unrelated to clk
   initial begin
      link_k = 1'b0;
      link_kn = 1'b1;
      read_sel_n = 1'b1;
      write_sel_n = 1'b1;
      addr = '0;
      lanes_n = '1;
      wdata = '0;
      #7;
      forever begin
         #HALF;
         link_k = ~link_k;
         link_kn = ~link_k;
      end
   end
   // ==========
   // One link cycle; pins move mid-half so both edges see settled values
   task automatic issue(input bit rd, input logic [AW-1:0] ra, input bit wr,
                        input logic [AW-1:0] wa, input logic [2*DW-1:0] d,
                        input logic [2*NL-1:0] l);
      @(posedge link_kn);
      #(HALF / 2);
      read_sel_n = ~rd;
      write_sel_n = ~wr;
      addr = rd ? ra : AW'($urandom);
      wdata = wr ? d[2*DW-1:DW] : ~wdata;
      lanes_n = wr ? l[2*NL-1:NL] : NL'($urandom);
      @(posedge link_k);
      #(HALF / 2);
      read_sel_n = 1'b1;
      write_sel_n = 1'b1;
      addr = wr ? wa : AW'($urandom);
      wdata = wr ? d[DW-1:0] : ~wdata;
      lanes_n = wr ? l[NL-1:0] : NL'($urandom);
   endtask : issue
endmodule : dbsp_host_model
`default_nettype wire

// file: verification/ddr_burst2_sram_port_bench.sv
// Self-checking bench of the two-beat DDR static memory port
`timescale 1ns/1ps
`default_nettype none
module ddr_burst2_sram_port_bench
   import dbsp_pkg::*;
;
   localparam int DW = DW_X36;
   localparam int AW = AW_X36;
   localparam int NL = NL_X36;
   localparam int SAW = 10;
   localparam int POOL = 16;
   typedef logic [2*DW-1:0] dbsp_pair_t;
   typedef logic [2*NL-1:0] dbsp_lanes_t;
   logic clk, arst_n, ce, dll_off_n, live;
   logic k, kn, rsn, wsn, oe_n, vld, eck, eckn, eck_d, eckn_d, vld_d;
   logic [AW-1:0] addr;
   logic [NL-1:0] lanes_n;
   logic [DW-1:0] wdata, rdata;
   int err_count, n_compared, ph, echo_edges;
   logic [AW-1:0] pool [POOL];
   dbsp_pair_t mem [int];
   logic [DW-1:0] exp_q [$];
   time t_q [$];
   int lat_q [$];

   dbsp_host_model #(.AW(AW), .DW(DW), .NL(NL)) i_dbsp_host_model (
      .link_k(k), .link_kn(kn), .read_sel_n(rsn), .write_sel_n(wsn),
      .addr(addr), .lanes_n(lanes_n), .wdata(wdata));
   dbsp_sram_port #(.WIDE_ORG(1'b1), .STORE_AW(SAW)) i_dbsp_sram_port (
      .clk(clk), .arst_n(arst_n), .ce(ce), .input_clock_true(k),
      .input_clock_comp(kn), .read_sel_n(rsn), .write_sel_n(wsn),
      .shared_address_in(addr), .byte_lane_write_n(lanes_n),
      .write_data_in(wdata), .dll_off_n(dll_off_n), .read_data_out(rdata),
      .read_data_oe_n(oe_n), .read_valid_flag(vld), .echo_clock_true(eck),
      .echo_clock_comp(eckn));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ==========
   // Checking and verdict
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // ==========
   // Reference memory: expected beats of one read, from the model's word
   task automatic rd_push(input int ri);
      dbsp_pair_t m;
      m = mem[int'(pool[ri][SAW-1:0])];
      exp_q.push_back(m[2*DW-1:DW]);
      exp_q.push_back(m[DW-1:0]);
      t_q.push_back($time - 50);
      lat_q.push_back(int'(dll_off_n));
   endtask : rd_push

   // A read sees the write of its own cycle only when its fetch comes a cycle later
   task automatic op(input bit rd, input int ri, input bit wr, input int wi,
                     input dbsp_pair_t d, input dbsp_lanes_t l);
      dbsp_pair_t m;
      int a;
      i_dbsp_host_model.issue(rd, pool[ri], wr, pool[wi], d, l);
      // One-cycle fetch shares the K# edge of this write and misses it
      if (rd && !dll_off_n) rd_push(ri);
      if (wr) begin
         a = int'(pool[wi][SAW-1:0]);
         m = mem.exists(a) ? mem[a] : '0;
         for (int i = 0; i < 2*NL; i++) begin
            if (!l[i]) m[LANE_W*i +: LANE_W] = d[LANE_W*i +: LANE_W];
         end
         mem[a] = m;
      end
      // Two-cycle fetch comes after this cycle's write has landed
      if (rd && dll_off_n) rd_push(ri);
   endtask : op

   task automatic traffic(input int n);
      repeat (n) begin
         op($urandom % 4 != 0, $urandom % POOL, $urandom % 4 != 0, $urandom % POOL,
            dbsp_pair_t'({$urandom, $urandom, $urandom}), dbsp_lanes_t'($urandom));
      end
   endtask : traffic

   // Write and read one word per cycle through the buffer, then freeze the clock enable
   task automatic buf_test();
      logic [DW-1:0] held;
      int e1;
      for (int i = 0; i < WBUF_DEPTH; i++) begin
         op(1, i, 1, i, dbsp_pair_t'({$urandom, $urandom, $urandom}),
            dbsp_lanes_t'($urandom));
      end
      repeat (4) op(0, 0, 0, 0, '0, '0);
      chk(DW'(exp_q.size()), '0);
      @(negedge clk);
      ce = 1'b0;
      @(negedge clk);
      e1 = echo_edges;
      held = rdata;
      repeat (3) @(negedge clk);
      chk(DW'(echo_edges - e1), '0);
      chk(rdata, held);
      ce = 1'b1;
   endtask : buf_test

   // ==========
   // Output monitor, sampled mid-cycle
   always @(negedge clk) begin
      int dt;
      if (live) begin
         chk(DW'(eckn ^ eck), DW'(1));
         chk(DW'(oe_n ^ vld), DW'(1));
         if (eck !== eck_d) echo_edges++;
         if (vld === 1'b1 && vld_d_n()) begin
            ph = 0;
            chk(DW'({eckn_d, eckn}), DW'(2'b01));
         end else begin
            ph++;
         end
         if (vld === 1'b1 && ph % 4 == 1) begin
            if (exp_q.size() == 0) chk(DW'(exp_q.size()), DW'(1));
            else chk(rdata, exp_q.pop_front());
            if (ph % 8 == 1 && t_q.size() > 0) begin
               dt = int'($time - t_q.pop_front());
               chk(DW'(dt - 200 * lat_q.pop_front() inside {[120:250]}), DW'(1));
            end
         end
      end
      eck_d <= eck;
      eckn_d <= eckn;
      vld_d <= vld;
   end
   function automatic bit vld_d_n();
      return vld_d !== 1'b1;
   endfunction : vld_d_n

   // ==========
   // Main sequence
   initial begin
      int e0;
      ce = 1'b1;
      dll_off_n = 1'b1;
      arst_n = 1'b0;
      live = 1'b0;
      err_count = 0;
      n_compared = 0;
      echo_edges = 0;
      void'($urandom(32'h26b8));
      repeat (8) @(negedge clk);
      chk(DW'({oe_n, vld}), DW'(2'b10)); // reset state
      arst_n = 1'b1;
      for (int i = 0; i < POOL; i++) begin
         pool[i] = AW'($urandom);
      end
      repeat (2) op(0, 0, 0, 0, '0, '0);
      live = 1'b1;
      for (int i = 0; i < POOL; i++) begin
         op(0, 0, 1, i, dbsp_pair_t'({$urandom, $urandom, $urandom}), '0);
      end
      for (int i = 0; i < POOL; i++) begin
         op(1, i, 1, (i + 1) % POOL, dbsp_pair_t'({$urandom, $urandom, $urandom}),
            dbsp_lanes_t'($urandom));
      end
      traffic(150);
      repeat (6) op(0, 0, 0, 0, '0, '0);
      e0 = echo_edges;
      repeat (10) op(0, 0, 0, 0, '0, '0);
      chk(DW'(echo_edges - e0 inside {[19:21]}), DW'(1));
      @(negedge clk);
      dll_off_n = 1'b0;
      repeat (2) op(0, 0, 0, 0, '0, '0);
      traffic(20);
      repeat (6) op(0, 0, 0, 0, '0, '0);
      @(negedge clk);
      dll_off_n = 1'b1;
      buf_test();
      chk(DW'(exp_q.size()), '0); // every read answered
      test_done();
   end

   initial begin
      #1000000;
      err_count++;
      test_done();
   end
endmodule : ddr_burst2_sram_port_bench
`default_nettype wire
